/* core/caf_consts.vh */
`ifndef CAF_CONSTS_VH
`define CAF_CONSTS_VH
// register access encodings on the documented register port
`define CAF_SEL_ENABLE     2'h0
`define CAF_SEL_MASK       2'h1
`define CAF_SEL_MATCH      2'h2
`define CAF_SEL_STATUS     2'h3
// identifier word fields, shared by mask and match
`define CAF_STD_HI         31
`define CAF_STD_LO         21
`define CAF_SUBST_BIT      20
`define CAF_EXT_FLAG_BIT   19
`define CAF_EXT_HI         18
`define CAF_EXT_LO         1
`define CAF_REMOTE_BIT     0
// filter enable register
`define CAF_MAX_FILTERS    4
`define CAF_USE_BITS       4
`define CAF_ENABLE_RESET   4'h0
`define CAF_WORD_ZERO      32'h0000_0000
// status register: busy flag position
`define CAF_BUSY_BIT       0
`endif

/* core/caf_filter.v */
`include "caf_consts.vh"
`default_nettype none
module caf_filter #(
  parameter NUM_FILTERS = 4            // build-time filter count, 0..4
) (
  // clock and reset
  input  wire        clock,
  input  wire        resetn,
  // host register port
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [1:0]  reg_sel,
  input  wire [1:0]  reg_idx,
  input  wire [31:0] reg_wdata,
  output reg  [31:0] reg_rdata,
  output reg         reg_rvalid,
  // receive path
  input  wire        rx_id_valid,
  input  wire [31:0] rx_id_word,
  input  wire        rx_frame_active,
  // decision
  output reg         accept_valid,
  output reg         accept,
  output reg         filter_busy_flag
);
  // states, one-hot; one compare takes two cycles because the ram
  // answers a cycle late, traded against four parallel comparators
  localparam [3:0] ST_IDLE = 4'b0001;  // waiting for an identifier
  localparam [3:0] ST_READ = 4'b0010;  // memory address presented
  localparam [3:0] ST_CMP  = 4'b0100;  // compare one pair
  localparam [3:0] ST_DONE = 4'b1000;  // publish decision

  // use bits mask of built filters; a count above four is taken as
  // four, a count of zero leaves no pairs: the enable register then
  // reads zero and every frame is stored
  localparam [3:0] BUILT = (NUM_FILTERS >= 4) ? 4'hF :
                           (NUM_FILTERS == 3) ? 4'h7 :
                           (NUM_FILTERS == 2) ? 4'h3 :
                           (NUM_FILTERS == 1) ? 4'h1 : 4'h0;

  // sequencer and host read registers
  reg  [3:0]  state_r;              // filter sequencer
  reg  [3:0]  filter_use_bit_r;     // enable register contents
  reg  [31:0] id_r;                 // captured identifier
  reg  [1:0]  idx_r;                // pair under test
  reg         hit_r;                // any pass so far
  reg         drop_r;               // use bit fell mid-frame
  reg         rd_pend_r;            // host read waiting on ram
  reg  [1:0]  rd_sel_r;             // which ram the host read
  reg  [1:0]  rd_idx_r;             // which pair the host read
  reg         ram_host_r;           // ram output holds a host word
  // ram outputs and decode helpers
  wire [31:0] mask_q;               // mask ram output
  wire [31:0] match_q;              // match ram output
  wire        host_ram_wr;          // host write to either ram
  wire [1:0]  ram_rd_idx;           // shared ram read address
  wire        pass_now;             // pair under test passes
  wire [3:0]  active_use;           // built and enabled pairs

  // a use bit only counts when its pair exists in this build
  assign active_use  = filter_use_bit_r & BUILT;
  // host ram writes only when pairs exist; with none built the
  // locations read back zero, so storing would only waste power
  assign host_ram_wr = reg_wr && (BUILT != 4'h0) &&
                       ((reg_sel == `CAF_SEL_MASK) || (reg_sel == `CAF_SEL_MATCH));
  // evaluation needs the read port only while in the read state;
  // every other cycle it serves the host, so a host read is not
  // starved by a long walk over the pairs
  assign ram_rd_idx  = (state_r == ST_READ) ? idx_r :
                       (rd_pend_r ? rd_idx_r : reg_idx);
  // masked compare: both sides masked, equal means pass; the ide bit
  // sits inside the word, so standard/extended selection needs no
  // separate logic
  assign pass_now = ((id_r & mask_q) == (match_q & mask_q));

  // both rams share one write and one read address, so a single
  // index walks mask and match together
  // mask storage
  caf_pair_ram u_mask (
    .clock   (clock),
    .wr_en   (host_ram_wr && (reg_sel == `CAF_SEL_MASK)),
    .wr_idx  (reg_idx),
    .wr_data (reg_wdata),
    .rd_idx  (ram_rd_idx),
    .rd_data (mask_q)
  );

  // match storage
  caf_pair_ram u_match (
    .clock   (clock),
    .wr_en   (host_ram_wr && (reg_sel == `CAF_SEL_MATCH)),
    .wr_idx  (reg_idx),
    .wr_data (reg_wdata),
    .rd_idx  (ram_rd_idx),
    .rd_data (match_q)
  );

  // enable register, only built positions are stored
  // written any cycle; a write clearing a bit mid-frame is also
  // seen by the drop logic of the sequencer
  always @(posedge clock)
  begin
    if (!resetn)
    begin
      // use bits clear on reset, the pair rams keep their words
      filter_use_bit_r <= `CAF_ENABLE_RESET;
    end
    else if (reg_wr && (reg_sel == `CAF_SEL_ENABLE))
    begin
      // reserved bits are not stored and read back zero
      filter_use_bit_r <= reg_wdata[`CAF_USE_BITS-1:0] & BUILT;
    end
  end

  // filter sequencer: walks all four pairs, one per two cycles
  // every pair is visited even when disabled, so a decision always
  // lands a fixed time after the identifier is taken whenever a pair is enabled
  always @(posedge clock)
  begin
    if (!resetn)
    begin
      // outputs start low; pair contents are left alone
      state_r          <= ST_IDLE;
      id_r             <= `CAF_WORD_ZERO;
      idx_r            <= 2'h0;
      hit_r            <= 1'b0;
      drop_r           <= 1'b0;
      accept_valid     <= 1'b0;
      accept           <= 1'b0;
      filter_busy_flag <= 1'b0;
    end
    else
    begin
      // decision strobe defaults low, raised only in the done state
      accept_valid <= 1'b0;
      case (state_r)
        ST_IDLE:
        begin
          // identifiers are taken only here; pulses during a walk are lost
          if (rx_id_valid)
          begin
            // the word is kept whole: ide and srr take part in the compare
            id_r  <= rx_id_word;
            hit_r <= 1'b0;
            idx_r <= 2'h0;
            if (active_use == 4'h0)
            begin
              // nothing enabled: skip the walk and store the frame
              state_r <= ST_DONE;
              hit_r   <= 1'b1;
            end
            else
            begin
              state_r          <= ST_READ;
              filter_busy_flag <= 1'b1;
            end
          end
          else
          begin
            // no frame in decision: forget a stale drop request
            drop_r <= 1'b0;
          end
        end
        ST_READ:
        begin
          // ram read started with idx_r, data ready next cycle
          // the compare itself happens in the next state
          state_r <= ST_CMP;
        end
        ST_CMP:
        begin
          // disabled pairs are walked too, their result is ignored
          // any passing enabled pair is enough to store the frame
          if (active_use[idx_r] && pass_now)
          begin
            hit_r <= 1'b1;
          end
          // last pair done: the ram is free for host writes again
          if (idx_r == 2'h3)
          begin
            state_r          <= ST_DONE;
            filter_busy_flag <= 1'b0;
          end
          else
          begin
            // on to the next pair
            idx_r   <= idx_r + 2'h1;
            state_r <= ST_READ;
          end
        end
        ST_DONE:
        begin
          // decision out well inside a frame time
          // accept holds until the next decision; a drop refuses the frame
          accept_valid <= 1'b1;
          accept       <= hit_r && !drop_r;
          drop_r       <= 1'b0;
          state_r      <= ST_IDLE;
        end
        default:
        begin
          // unreachable code: recover to idle, never stay busy
          state_r          <= ST_IDLE;
          filter_busy_flag <= 1'b0;
        end
      endcase
      // a use bit falling during a frame flags it for dropping; placed
      // after the state logic so that the set wins over the clears in
      // idle and done when both fall in one cycle
      if (rx_frame_active && reg_wr && (reg_sel == `CAF_SEL_ENABLE) &&
          |(filter_use_bit_r & ~(reg_wdata[`CAF_USE_BITS-1:0] & BUILT)))
      begin
        drop_r <= 1'b1;
      end
    end
  end

  // host read path; ram reads take one cycle, shared with evaluation
  // a pending mask/match read completes once the ram output was
  // loaded from the host's address at the previous edge
  always @(posedge clock)
  begin
    if (!resetn)
    begin
      reg_rdata  <= `CAF_WORD_ZERO;
      reg_rvalid <= 1'b0;
      rd_pend_r  <= 1'b0;
      rd_sel_r   <= `CAF_SEL_ENABLE;
      rd_idx_r   <= 2'h0;
      ram_host_r <= 1'b0;
    end
    else
    begin
      reg_rvalid <= 1'b0;
      // the ram serves the host on every edge outside the read state
      ram_host_r <= (state_r != ST_READ);
      if (rd_pend_r && ram_host_r)
      begin
        // ram output now holds the host's word
        rd_pend_r  <= 1'b0;
        reg_rvalid <= 1'b1;
        // with no pairs built the locations read zero
        reg_rdata  <= (BUILT == 4'h0) ? `CAF_WORD_ZERO :
                      (rd_sel_r == `CAF_SEL_MASK) ? mask_q : match_q;
      end
      // a read arriving while one is pending is ignored
      else if (reg_rd && !rd_pend_r)
      begin
        case (reg_sel)
          `CAF_SEL_ENABLE:
          begin
            // reserved and unbuilt bits read zero
            // answered at once from flops, no ram access
            reg_rdata  <= {28'h000_0000, filter_use_bit_r & BUILT};
            reg_rvalid <= 1'b1;
          end
          `CAF_SEL_STATUS:
          begin
            // busy shows a walk in progress; pair writes must wait
            reg_rdata  <= {31'h0000_0000, filter_busy_flag};
            reg_rvalid <= 1'b1;
          end
          default:
          begin
            // mask/match: data follows from the ram; the address is
            // kept so that the host need not hold reg_idx meanwhile
            rd_pend_r <= 1'b1;
            rd_sel_r  <= reg_sel;
            rd_idx_r  <= reg_idx;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

/* core/caf_pair_ram.v */
`include "caf_consts.vh"
`default_nettype none
// simple dual-port storage for the four mask or four match words; no reset on
// purpose, so contents survive system and software reset
module caf_pair_ram (
  // clock
  input  wire        clock,
  // write side
  input  wire        wr_en,
  input  wire [1:0]  wr_idx,
  input  wire [31:0] wr_data,
  // read side, one cycle latency
  input  wire [1:0]  rd_idx,
  output reg  [31:0] rd_data
);
  reg [31:0] mem [0:`CAF_MAX_FILTERS-1];  // four words

  // synchronous write and read, block memory style
  always @(posedge clock)
  begin
    if (wr_en)
    begin
      mem[wr_idx] <= wr_data;
    end
    rd_data <= mem[rd_idx];
  end
endmodule
`default_nettype wire

/* verif/caf_filter_assertions.sv */
`default_nettype none
module caf_filter_assertions #(parameter NUM_FILTERS = 4) (
  // watched ports
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic        reg_rd,
  input wire logic [1:0]  reg_sel,
  input wire logic [31:0] reg_rdata,
  input wire logic        reg_rvalid,
  input wire logic        rx_id_valid,
  input wire logic        accept_valid,
  input wire logic        accept,
  input wire logic        filter_busy_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  a_busy_eight_cycles: assert property (
    $rose(filter_busy_flag) |-> filter_busy_flag[*8] ##1 !filter_busy_flag) else $error("busy len");
  a_decision_after_busy: assert property (
    $rose(filter_busy_flag) |-> ##9 accept_valid) else $error("decision late");
  a_decision_pulse: assert property (
    accept_valid |=> !accept_valid) else $error("decision not a pulse");
  a_accept_holds: assert property (
    !accept_valid && $past(resetn) |-> $stable(accept)) else $error("accept moved");
  a_bypass_accepts: assert property (
    accept_valid && !$past(filter_busy_flag, 2) |-> accept) else $error("bypass refused");
  a_enable_read_bits: assert property (
    reg_rd && reg_sel == 2'h0 |=> reg_rvalid && (reg_rdata >> NUM_FILTERS) == 32'h0)
    else $error("enable read bits");
  a_status_busy_read: assert property (
    reg_rd && reg_sel == 2'h3 |=> reg_rvalid && reg_rdata[0] == $past(filter_busy_flag))
    else $error("status busy bit");
  a_pair_read_time: assert property (
    reg_rd && (reg_sel[0] ^ reg_sel[1]) && !filter_busy_flag && !rx_id_valid
    && !$past(rx_id_valid) |-> ##2 reg_rvalid) else $error("pair read late");
  a_read_pulse: assert property (
    reg_rvalid |=> !reg_rvalid) else $error("read valid not a pulse");
endmodule
bind caf_filter caf_filter_assertions #(.NUM_FILTERS(NUM_FILTERS)) i_caf_filter_assertions (
  .clock(clock), .resetn(resetn), .reg_rd(reg_rd), .reg_sel(reg_sel),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .rx_id_valid(rx_id_valid),
  .accept_valid(accept_valid), .accept(accept), .filter_busy_flag(filter_busy_flag));
`default_nettype wire

/* verif/caf_filter_test.sv */
`default_nettype none
module caf_filter_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, resetn, reg_wr, reg_rd, go, rx_id_valid, rx_frame_active, acc;
  logic accept_valid, accept, filter_busy_flag, reg_rvalid;
  logic [1:0] reg_sel, reg_idx;
  logic [31:0] reg_wdata, reg_rdata, rx_id_word, word, rd;
  int mismatches = 0, samples_checked = 0, k;
  typedef struct {logic [31:0] en, m, a, id; logic [1:0] ix; logic ex;} caf_row_t;
  // use bits (built filters only), mask, match, id, pair, expected store;
  // ids keep the frame layout, extended filters set every mask field
  caf_row_t rows[9] = '{
    '{32'h0, 32'hFFE0_0000, 32'h2460_0000, 32'h1234_5678, 2'h0, 1'b1},
    '{32'h1, 32'hFFE0_0000, 32'h2460_0000, 32'h2460_0000, 2'h0, 1'b1},
    '{32'h1, 32'hFFE0_0000, 32'h2460_0000, 32'h2480_0000, 2'h0, 1'b0},
    '{32'h1, 32'hFFE8_0000, 32'h2460_0000, 32'h2479_5554, 2'h0, 1'b0},
    '{32'h1, 32'hFFE0_0000, 32'h2460_0000, 32'h2479_5554, 2'h0, 1'b1},
    '{32'h2, 32'hFFFF_FFFF, 32'h2479_5554, 32'h2479_5554, 2'h1, 1'b1},
    '{32'h3, 32'hFFFF_FFFF, 32'h2479_5556, 32'h2460_0000, 2'h1, 1'b1},
    '{32'h8, 32'hFFFF_FFFF, 32'h0000_0000, 32'h2460_0000, 2'h3, 1'b0},
    '{32'h2, 32'hFFFF_FFFF, 32'h2479_5556, 32'h2479_5554, 2'h1, 1'b0}};
  caf_filter #(.NUM_FILTERS(4)) i_caf_filter (.clock(clock), .resetn(resetn),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_sel(reg_sel), .reg_idx(reg_idx),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .rx_id_valid(rx_id_valid), .rx_id_word(rx_id_word), .rx_frame_active(rx_frame_active),
    .accept_valid(accept_valid), .accept(accept), .filter_busy_flag(filter_busy_flag));
  caf_rx_model i_caf_rx_model (.clock(clock), .go(go), .word(word),
    .rx_id_valid(rx_id_valid), .rx_id_word(rx_id_word), .rx_frame_active(rx_frame_active));
  initial
  begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  task automatic results;
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // the write strobe drops for a cycle before the next access
  task automatic wr(input logic [1:0] s, input logic [1:0] i, input logic [31:0] d);
    {reg_wr, reg_sel, reg_idx, reg_wdata} = {1'b1, s, i, d};
    @(posedge clock); #1 reg_wr = 0;
    @(posedge clock); #1;
  endtask
  task automatic rd_reg(input logic [1:0] s, input logic [1:0] i);
    {reg_rd, reg_sel, reg_idx} = {1'b1, s, i};
    @(posedge clock); #1 reg_rd = 0;
    // enable and status answer at the request edge: look before waiting
    for (k = 0; k < 20; k++)
    begin
      if (reg_rvalid === 1'b1) break;
      @(posedge clock); #1;
    end
    rd = reg_rdata;
    if (k == 20) begin mismatches++; results(); end
  endtask
  task automatic launch(input logic [31:0] w);
    word = w;
    go = 1;
    @(posedge clock); #1 go = 0;
  endtask
  task automatic wait_dec;
    for (k = 0; k < 30; k++)
    begin
      @(posedge clock); #1;
      if (accept_valid === 1'b1) break;
    end
    acc = accept;
    if (k == 30) begin mismatches++; results(); end
    repeat (2) @(posedge clock); #1;
  endtask
  initial
  begin
    {resetn, reg_wr, reg_rd, reg_sel, reg_idx, reg_wdata, go, word} = '0;
    repeat (6) @(posedge clock); #1 resetn = 1;
    rd_reg(2'h0, 2'h0); chk(rd, 32'h0);
    foreach (rows[r])
    begin
      wr(2'h0, 2'h0, 32'h0); // pair edited only while unused and idle
      wr(2'h1, rows[r].ix, rows[r].m);
      wr(2'h2, rows[r].ix, rows[r].a);
      rd_reg(2'h1, rows[r].ix); chk(rd, rows[r].m);
      wr(2'h0, 2'h0, rows[r].en);
      launch(rows[r].id);
      wait_dec;
      chk({31'h0, acc}, {31'h0, rows[r].ex});
    end
    wr(2'h0, 2'h0, 32'hFFFF_FFFF);
    rd_reg(2'h0, 2'h0); chk(rd, 32'h0000_000F);
    launch(32'h2460_0000);
    repeat (3) @(posedge clock); #1;
    rd_reg(2'h3, 2'h0); chk(rd & 32'h1, 32'h1);
    wait_dec;
    chk({31'h0, acc}, 32'h1);
    resetn = 0;
    @(posedge clock); #1 resetn = 1;
    rd_reg(2'h0, 2'h0); chk(rd, 32'h0);
    rd_reg(2'h1, 2'h3); chk(rd, 32'hFFFF_FFFF);
    rd_reg(2'h2, 2'h1); chk(rd, 32'h2479_5556);
    launch(32'h0000_0000);
    wait_dec;
    chk({31'h0, acc}, 32'h1);
    results();
  end
endmodule
`default_nettype wire

/* verif/caf_rx_model.sv */
`default_nettype none
// receive path stand-in: frame window, one id pulse, stale word toggles
module caf_rx_model (
  input  wire logic        clock,
  input  wire logic        go,
  input  wire logic [31:0] word,
  output var  logic        rx_id_valid,
  output var  logic [31:0] rx_id_word,
  output var  logic        rx_frame_active
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_r;
  initial
  begin
    {rx_id_valid, rx_frame_active, cnt_r, rx_id_word} = '0;
  end
  // id word form per frame type comes from the bench rows
  always @(posedge clock)
  begin
    if (go) {rx_frame_active, cnt_r} <= {1'b1, 4'h6};
    else if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
    if (cnt_r == 4'h1) rx_frame_active <= 1'b0;
    rx_id_valid <= (cnt_r == 4'h6);
    rx_id_word <= (cnt_r == 4'h6) ? word : ~rx_id_word;
  end
endmodule
`default_nettype wire
